// ==== rtl/afsc_top.sv ====
// fan drive registers and automatic temperature-to-fan-speed controller
`timescale 1ns/1ps
module afsc_top #(
  parameter longint PWM_STEP_CYCLES = afsc_pkg::PWM_STEP_CYCLES,
  parameter longint SPINUP_CYCLES   = afsc_pkg::SPINUP_CYCLES
) (
  input  wire logic       MCLK,
  input  wire logic       RESET,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  output logic      [7:0] REG_RDATA,
  input  wire logic [7:0] TEMP_LOCAL,
  input  wire logic [7:0] TEMP_REMOTE1,
  input  wire logic [7:0] TEMP_REMOTE2,
  output logic      [7:0] DAC_CODE,
  output logic            PWM_O,
  output logic            PWM_OE,
  output logic            PWM_ACTIVE,
  output logic            FAN_RUNNING,
  output logic            FAN_INT
);

  //----------------------------------------------------------------------------
  // ramp function for one channel
  //----------------------------------------------------------------------------
  function automatic logic [7:0] afsc_ramp(
    input logic [7:0] temp,
    input logic [7:0] start,
    input logic [7:0] lo,
    input logic [7:0] hi,
    input logic [7:0] over
  );
    logic signed [8:0] diff;
    logic [12:0]       prod;
    logic [12:0]       step;
    diff = $signed({temp[7], temp}) - $signed({start[7], start});
    prod = 13'h0;
    step = 13'h0;
    if (diff <= afsc_pkg::ZERO_DEG) begin
      afsc_ramp = lo;
    end else if ($signed({4'h0, diff}) > $signed(afsc_pkg::RAMP_SPAN_DEG)) begin
      afsc_ramp = over;
    end else begin
      prod = 13'(hi - lo) * 13'(diff[4:0]);
      step = prod / afsc_pkg::RAMP_SPAN_DEG;
      afsc_ramp = lo + step[7:0];
    end
  endfunction : afsc_ramp

  function automatic logic afsc_above(input logic [7:0] temp, input logic [7:0] start);
    afsc_above = $signed(temp) > $signed(start);
  endfunction : afsc_above

  function automatic logic afsc_cool(input logic [7:0] temp, input logic [7:0] start);
    logic signed [8:0] diff;
    diff = $signed({temp[7], temp}) - $signed({start[7], start});
    afsc_cool = diff <= -afsc_pkg::HYST_DEG;
  endfunction : afsc_cool

  //----------------------------------------------------------------------------
  // register file
  //----------------------------------------------------------------------------
  logic [7:0] config1_ff;
  logic [7:0] nxt_config1;
  logic [7:0] analog_drive_code_ff;
  logic [7:0] nxt_analog_drive_code;
  logic [7:0] pulse_duty_setting_ff;
  logic [7:0] nxt_pulse_duty_setting;
  logic [7:0] fan_start_threshold_ff [afsc_pkg::NUM_SENSORS];
  logic [7:0] nxt_fan_start_threshold [afsc_pkg::NUM_SENSORS];
  logic [7:0] test1_ff;
  logic [7:0] nxt_test1;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_config1            = config1_ff;
    nxt_analog_drive_code  = analog_drive_code_ff;
    nxt_pulse_duty_setting = pulse_duty_setting_ff;
    nxt_test1              = test1_ff;
    nxt_fan_start_threshold = fan_start_threshold_ff;
    if (REG_WR) begin
      case (REG_ADDR)
        afsc_pkg::ADDR_CONFIG1:      nxt_config1 = REG_WDATA;
        afsc_pkg::ADDR_ANALOG_DRIVE: nxt_analog_drive_code = REG_WDATA;
        afsc_pkg::ADDR_PULSE_DUTY:   nxt_pulse_duty_setting = REG_WDATA;
        afsc_pkg::ADDR_THRESHOLD_A:  nxt_fan_start_threshold[0] = REG_WDATA;
        afsc_pkg::ADDR_THRESHOLD_B:  nxt_fan_start_threshold[1] = REG_WDATA;
        afsc_pkg::ADDR_THRESHOLD_C:  nxt_fan_start_threshold[2] = REG_WDATA;
        afsc_pkg::ADDR_TEST1:        nxt_test1 = REG_WDATA;
        default:                     nxt_config1 = config1_ff;
      endcase
    end
    case (REG_ADDR)
      afsc_pkg::ADDR_CONFIG1:      nxt_rdata = config1_ff;
      afsc_pkg::ADDR_ANALOG_DRIVE: nxt_rdata = analog_drive_code_ff;
      afsc_pkg::ADDR_PULSE_DUTY:   nxt_rdata = pulse_duty_setting_ff;
      afsc_pkg::ADDR_THRESHOLD_A:  nxt_rdata = fan_start_threshold_ff[0];
      afsc_pkg::ADDR_THRESHOLD_B:  nxt_rdata = fan_start_threshold_ff[1];
      afsc_pkg::ADDR_THRESHOLD_C:  nxt_rdata = fan_start_threshold_ff[2];
      afsc_pkg::ADDR_TEST1:        nxt_rdata = test1_ff;
      default:                     nxt_rdata = afsc_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      config1_ff            <= afsc_pkg::RST_CONFIG1;
      analog_drive_code_ff  <= afsc_pkg::RST_ANALOG_DRIVE;
      pulse_duty_setting_ff <= afsc_pkg::RST_PULSE_DUTY;
      test1_ff              <= afsc_pkg::RST_TEST1;
      rdata_ff              <= afsc_pkg::READ_UNMAPPED;
      for (int i = 0; i < afsc_pkg::NUM_SENSORS; i++) begin
        fan_start_threshold_ff[i] <= afsc_pkg::RST_THRESHOLD;
      end
    end else begin
      config1_ff             <= nxt_config1;
      analog_drive_code_ff   <= nxt_analog_drive_code;
      pulse_duty_setting_ff  <= nxt_pulse_duty_setting;
      test1_ff               <= nxt_test1;
      rdata_ff               <= nxt_rdata;
      fan_start_threshold_ff <= nxt_fan_start_threshold;
    end
  end

  //----------------------------------------------------------------------------
  // mode decode and minima
  //----------------------------------------------------------------------------
  logic       monitor_on;
  logic       auto_dac;
  logic       auto_pwm;
  logic       auto_any;
  logic [3:0] dac_nibble;
  logic [3:0] pwm_nibble;
  logic [7:0] dac_min;
  logic [7:0] pwm_min;

  assign monitor_on = config1_ff[afsc_pkg::CFG_MONITOR_BIT];
  assign auto_dac   = monitor_on & config1_ff[afsc_pkg::CFG_AUTO_DAC_BIT];
  assign auto_pwm   = monitor_on & config1_ff[afsc_pkg::CFG_AUTO_PWM_BIT];
  assign auto_any   = auto_dac | auto_pwm;
  assign dac_nibble = analog_drive_code_ff[7:4];
  // with both automated the pulse minimum follows the analog nibble
  assign pwm_nibble = auto_dac ? analog_drive_code_ff[7:4] : pulse_duty_setting_ff[7:4];
  assign dac_min    = 8'({4'h0, dac_nibble} * afsc_pkg::DAC_MIN_STEP);
  assign pwm_min    = 8'({4'h0, pwm_nibble} * afsc_pkg::PWM_MIN_STEP);

  //----------------------------------------------------------------------------
  // per-channel demand
  //----------------------------------------------------------------------------
  logic [7:0] temps     [afsc_pkg::NUM_SENSORS];
  logic [7:0] dac_req   [afsc_pkg::NUM_SENSORS];
  logic [7:0] pwm_req   [afsc_pkg::NUM_SENSORS];
  logic [afsc_pkg::NUM_SENSORS-1:0] hot;
  logic [afsc_pkg::NUM_SENSORS-1:0] cool;

  assign temps[0] = TEMP_LOCAL;
  assign temps[1] = TEMP_REMOTE1;
  assign temps[2] = TEMP_REMOTE2;

  generate
    for (genvar g = 0; g < afsc_pkg::NUM_SENSORS; g++) begin : g_chan
      assign dac_req[g] = afsc_ramp(temps[g], fan_start_threshold_ff[g], dac_min,
                                    afsc_pkg::DAC_RAMP_TOP, afsc_pkg::DRIVE_FULL);
      assign pwm_req[g] = afsc_ramp(temps[g], fan_start_threshold_ff[g], pwm_min,
                                    afsc_pkg::PWM_RAMP_TOP, afsc_pkg::DRIVE_FULL);
      assign hot[g]     = afsc_above(temps[g], fan_start_threshold_ff[g]);
      assign cool[g]    = afsc_cool(temps[g], fan_start_threshold_ff[g]);
    end
  endgenerate

  logic [7:0] dac_max;
  logic [7:0] pwm_max;

  always_comb begin
    dac_max = dac_req[0];
    pwm_max = pwm_req[0];
    for (int i = 1; i < afsc_pkg::NUM_SENSORS; i++) begin
      if (dac_req[i] > dac_max) dac_max = dac_req[i];
      if (pwm_req[i] > pwm_max) pwm_max = pwm_req[i];
    end
  end

  //----------------------------------------------------------------------------
  // fan state machine
  //----------------------------------------------------------------------------
  afsc_pkg::afsc_fan_state_type state_ff;
  afsc_pkg::afsc_fan_state_type nxt_state;
  logic [31:0] spin_ff;
  logic [31:0] nxt_spin;
  logic        int_ff;
  logic        nxt_int;

  always_comb begin
    nxt_state = state_ff;
    nxt_spin  = spin_ff;
    nxt_int   = 1'b0;
    case (state_ff)
      afsc_pkg::FAN_OFF: begin
        nxt_spin = 32'h0;
        if (auto_any && (|hot)) begin
          nxt_state = afsc_pkg::FAN_SPINUP;
          nxt_int   = 1'b1;
        end
      end
      afsc_pkg::FAN_SPINUP: begin
        nxt_spin = spin_ff + 32'h1;
        if (spin_ff >= 32'(SPINUP_CYCLES - 1)) begin
          nxt_state = afsc_pkg::FAN_RUN;
        end
      end
      afsc_pkg::FAN_RUN: begin
        nxt_spin = 32'h0;
        if (&cool) begin
          nxt_state = afsc_pkg::FAN_OFF;
          nxt_int   = 1'b1;
        end
      end
      default: begin
        nxt_state = afsc_pkg::FAN_OFF;
        nxt_spin  = 32'h0;
      end
    endcase
    // leaving automatic mode parks the machine without an event
    if (!auto_any) begin
      nxt_state = afsc_pkg::FAN_OFF;
      nxt_spin  = 32'h0;
      nxt_int   = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state_ff <= afsc_pkg::FAN_OFF;
      spin_ff  <= 32'h0;
      int_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      spin_ff  <= nxt_spin;
      int_ff   <= nxt_int;
    end
  end

  //----------------------------------------------------------------------------
  // output selection
  //----------------------------------------------------------------------------
  logic [7:0] dac_ff;
  logic [7:0] nxt_dac;
  logic [7:0] duty_ff;
  logic [7:0] nxt_duty;
  logic [7:0] auto_dac_val;
  logic [7:0] auto_pwm_val;

  always_comb begin
    case (state_ff)
      afsc_pkg::FAN_SPINUP: begin
        auto_dac_val = afsc_pkg::DRIVE_FULL;
        auto_pwm_val = afsc_pkg::DRIVE_FULL;
      end
      afsc_pkg::FAN_RUN: begin
        auto_dac_val = dac_max;
        auto_pwm_val = pwm_max;
      end
      default: begin
        auto_dac_val = afsc_pkg::DRIVE_OFF;
        auto_pwm_val = afsc_pkg::DRIVE_OFF;
      end
    endcase
    nxt_dac  = auto_dac ? auto_dac_val : analog_drive_code_ff;
    nxt_duty = auto_pwm ? auto_pwm_val : pulse_duty_setting_ff;
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      dac_ff  <= afsc_pkg::RST_ANALOG_DRIVE;
      duty_ff <= afsc_pkg::RST_PULSE_DUTY;
    end else begin
      dac_ff  <= nxt_dac;
      duty_ff <= nxt_duty;
    end
  end

  //----------------------------------------------------------------------------
  // pulse generator
  //----------------------------------------------------------------------------
  afsc_pwm_if pwm_bus ();

  assign pwm_bus.duty   = duty_ff;
  assign pwm_bus.invert = test1_ff[afsc_pkg::TEST1_INVERT_BIT];

  afsc_pwm #(
    .STEP_CYCLES (int'(PWM_STEP_CYCLES))
  ) u_pwm (
    .clk    (MCLK),
    .rst    (RESET),
    .pwm    (pwm_bus.gen),
    .pin_oe (PWM_OE)
  );

  assign REG_RDATA   = rdata_ff;
  assign DAC_CODE    = dac_ff;
  assign PWM_O       = 1'b0;
  assign PWM_ACTIVE  = pwm_bus.active;
  assign FAN_RUNNING = (state_ff != afsc_pkg::FAN_OFF);
  assign FAN_INT     = int_ff;

endmodule : afsc_top

// ==== include/afsc_pkg.sv ====
// constants, register map and timing for the automatic fan speed controller
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
// Summary of operation
// - eight-bit analog drive code, resets to all ones
// - pulse output near 75 Hz from duty
// - test register bit one inverts pulse polarity
// - automatic control only while monitoring enabled
// - bits five, six enable analog, pulse automation
// - three signed start thresholds, one per sensor
// - upper nibbles set analog and pulse minimum
// - both automated: analog nibble sets both minima
// - minimum code 16 times D, duty 6.67% D
// - start: two seconds full drive, then the largest ramp demand
// - linear ramp over 20 degrees to 240/100%
// - beyond ramp analog code jumps to 255
// - largest demand of any channel sets each applied drive
// - stop when all sensors at or below threshold-4, or on leaving automatic mode
// - one-off interrupt on each start and each cool-down stop
// - temperatures signed, one degree per step
package afsc_pkg;

  //----------------------------------------------------------------------------
  // register map
  //----------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG1      = 8'h00;
  localparam logic [7:0] ADDR_ANALOG_DRIVE = 8'h04;
  localparam logic [7:0] ADDR_PULSE_DUTY   = 8'h05;
  localparam logic [7:0] ADDR_THRESHOLD_A  = 8'h10;
  localparam logic [7:0] ADDR_THRESHOLD_B  = 8'h11;
  localparam logic [7:0] ADDR_THRESHOLD_C  = 8'h12;
  localparam logic [7:0] ADDR_TEST1        = 8'h14;

  localparam int CFG_MONITOR_BIT    = 0;
  localparam int CFG_AUTO_DAC_BIT   = 5;
  localparam int CFG_AUTO_PWM_BIT   = 6;
  localparam int TEST1_INVERT_BIT   = 1;

  localparam logic [7:0] RST_CONFIG1      = 8'h00;
  localparam logic [7:0] RST_ANALOG_DRIVE = 8'hff;
  localparam logic [7:0] RST_PULSE_DUTY   = 8'hff;
  localparam logic [7:0] RST_THRESHOLD    = 8'h7f;
  localparam logic [7:0] RST_TEST1        = 8'h00;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  //----------------------------------------------------------------------------
  // transfer function
  //----------------------------------------------------------------------------
  localparam logic [7:0]  DRIVE_FULL      = 8'hff;
  localparam logic [7:0]  DRIVE_OFF       = 8'h00;
  localparam logic [7:0]  DAC_RAMP_TOP    = 8'hf0;
  localparam logic [7:0]  PWM_RAMP_TOP    = 8'hff;
  localparam logic [7:0]  DAC_MIN_STEP    = 8'h10;
  localparam logic [7:0]  PWM_MIN_STEP    = 8'h11;
  localparam logic [12:0] RAMP_SPAN_DEG   = 13'h0014;
  localparam logic signed [8:0] HYST_DEG  = 9'sh004;
  localparam logic signed [8:0] ZERO_DEG  = 9'sh000;
  localparam int NUM_SENSORS              = 3;

  //----------------------------------------------------------------------------
  // timing
  //----------------------------------------------------------------------------
  localparam longint CLK_HZ          = 100_000_000;
  localparam longint PWM_FREQ_HZ     = 75;
  localparam longint PWM_STEPS       = 255;
  localparam longint PWM_STEP_CYCLES = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
  localparam longint SPINUP_S        = 2;
  localparam longint SPINUP_CYCLES   = CLK_HZ * SPINUP_S;
  localparam logic [7:0] PWM_LAST_STEP = 8'hfe;

  typedef enum {FAN_OFF, FAN_SPINUP, FAN_RUN} afsc_fan_state_type;

endpackage : afsc_pkg

// ==== include/afsc_pwm_if.sv ====
// duty and polarity handed from the controller to the pulse generator
`timescale 1ns/1ps
interface afsc_pwm_if;
  logic [7:0] duty;
  logic       invert;
  logic       active;

  modport ctrl (output duty, output invert, input active);
  modport gen  (input duty, input invert, output active);
endinterface : afsc_pwm_if

// ==== rtl/afsc_pwm.sv ====
// pulse generator: 255 steps per period, open-drain pin enable
`timescale 1ns/1ps
module afsc_pwm #(
  parameter int STEP_CYCLES = 5228
) (
  input  wire logic   clk,
  input  wire logic   rst,
  afsc_pwm_if.gen     pwm,
  output logic        pin_oe
);

  logic [31:0] pre_ff;
  logic [31:0] nxt_pre;
  logic [7:0]  step_ff;
  logic [7:0]  nxt_step;
  logic        active_ff;
  logic        nxt_active;
  logic        oe_ff;
  logic        nxt_oe;

  always_comb begin
    nxt_pre    = pre_ff + 32'h1;
    nxt_step   = step_ff;
    if (pre_ff >= 32'(STEP_CYCLES - 1)) begin
      nxt_pre  = 32'h0;
      nxt_step = (step_ff >= afsc_pkg::PWM_LAST_STEP) ? 8'h00 : step_ff + 8'h01;
    end
    nxt_active = (step_ff < pwm.duty) || (pwm.duty == afsc_pkg::DRIVE_FULL);
    // pin released while driven high; pulled low otherwise
    nxt_oe     = ~(nxt_active ^ pwm.invert);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_ff    <= 32'h0;
      step_ff   <= 8'h00;
      active_ff <= 1'b0;
      oe_ff     <= 1'b1;
    end else begin
      pre_ff    <= nxt_pre;
      step_ff   <= nxt_step;
      active_ff <= nxt_active;
      oe_ff     <= nxt_oe;
    end
  end

  assign pwm.active = active_ff;
  assign pin_oe     = oe_ff;

endmodule : afsc_pwm

// ==== tb/afsc_fan_stage.sv ====
// fan driver stage model seen from the open-drain pulse pin
`timescale 1ns/1ps
module afsc_fan_stage (
  input  wire logic pull_low_oe,
  input  wire logic pin_drive,
  output logic      pin_level
);
  // released pin goes to the pull-up level
  assign pin_level = pull_low_oe ? pin_drive : 1'b1;
endmodule : afsc_fan_stage

// ==== tb/afsc_top_sva.sv ====
// concurrent checks on the fan controller ports
`timescale 1ns/1ps
module afsc_top_sva #(
  parameter longint PWM_STEP_CYCLES = 4,
  parameter longint SPINUP_CYCLES   = 20
) (
  input wire logic       MCLK,
  input wire logic       RESET,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic [7:0] REG_RDATA,
  input wire logic [7:0] TEMP_LOCAL,
  input wire logic [7:0] TEMP_REMOTE1,
  input wire logic [7:0] TEMP_REMOTE2,
  input wire logic [7:0] DAC_CODE,
  input wire logic       PWM_O,
  input wire logic       PWM_OE,
  input wire logic       PWM_ACTIVE,
  input wire logic       FAN_RUNNING,
  input wire logic       FAN_INT
);
  logic [7:0] cfg_ff, drv_ff, duty_ff, nxt_cfg, nxt_drv, nxt_duty;
  logic       inv_ff, nxt_inv;
  logic [2:0] age_ff, nxt_age;
  logic       auto_dac, auto_pwm;
  //----------------------------------------------------------------------------
  // shadow of the written registers, age since last write
  //----------------------------------------------------------------------------
  always_comb begin
    nxt_cfg  = (REG_WR && REG_ADDR == 8'h00) ? REG_WDATA : cfg_ff;
    nxt_drv  = (REG_WR && REG_ADDR == 8'h04) ? REG_WDATA : drv_ff;
    nxt_duty = (REG_WR && REG_ADDR == 8'h05) ? REG_WDATA : duty_ff;
    nxt_inv  = (REG_WR && REG_ADDR == 8'h14) ? REG_WDATA[1] : inv_ff;
    nxt_age  = REG_WR ? 3'h0 : (age_ff == 3'h7 ? age_ff : age_ff + 3'h1);
    if (RESET) begin
      nxt_cfg  = 8'h00;
      nxt_drv  = 8'hff;
      nxt_duty = 8'hff;
      nxt_inv  = 1'b0;
      nxt_age  = 3'h0;
    end
  end
  always_ff @(posedge MCLK) begin
    cfg_ff  <= nxt_cfg;
    drv_ff  <= nxt_drv;
    duty_ff <= nxt_duty;
    inv_ff  <= nxt_inv;
    age_ff  <= nxt_age;
  end
  assign auto_dac = cfg_ff[0] & cfg_ff[5];
  assign auto_pwm = cfg_ff[0] & cfg_ff[6];
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  reset_values_a: assert property ($fell(RESET) |-> DAC_CODE == 8'hff && PWM_OE
    && !PWM_ACTIVE && !FAN_RUNNING && !FAN_INT) else $error("bad output after reset");
  open_drain_a: assert property (PWM_O == 1'b0) else $error("pulse pin driven high");
  int_start_a: assert property ($rose(FAN_RUNNING) |-> FAN_INT)
    else $error("no interrupt on fan start");
  int_stop_a: assert property ($fell(FAN_RUNNING) && (auto_dac || auto_pwm) |-> FAN_INT)
    else $error("no interrupt on fan stop");
  int_single_a: assert property (FAN_INT |=> !FAN_INT) else $error("interrupt too long");
  int_cause_a: assert property (FAN_INT |-> $changed(FAN_RUNNING))
    else $error("interrupt without start or stop");
  spinup_full_a: assert property ($rose(FAN_RUNNING) && auto_dac |=>
    (DAC_CODE == 8'hff)[*8]) else $error("spin-up not at full drive");
  manual_dac_a: assert property (age_ff == 3'h7 && !auto_dac |-> DAC_CODE == drv_ff)
    else $error("manual drive code not applied");
  full_duty_a: assert property (age_ff == 3'h7 && !auto_pwm && duty_ff == 8'hff
    |-> PWM_ACTIVE) else $error("full duty not continuous");
  oe_polarity_a: assert property (age_ff == 3'h7 && $stable(PWM_ACTIVE)
    |-> PWM_OE == !(PWM_ACTIVE ^ inv_ff)) else $error("pin polarity wrong");
endmodule : afsc_top_sva

bind afsc_top afsc_top_sva #(.PWM_STEP_CYCLES(PWM_STEP_CYCLES), .SPINUP_CYCLES(SPINUP_CYCLES))
  sva (.MCLK(MCLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .TEMP_LOCAL(TEMP_LOCAL),
  .TEMP_REMOTE1(TEMP_REMOTE1), .TEMP_REMOTE2(TEMP_REMOTE2), .DAC_CODE(DAC_CODE),
  .PWM_O(PWM_O), .PWM_OE(PWM_OE), .PWM_ACTIVE(PWM_ACTIVE), .FAN_RUNNING(FAN_RUNNING),
  .FAN_INT(FAN_INT));

// ==== tb/test_auto_fan_speed_control.sv ====
// self-checking bench for the fan controller
`timescale 1ns/1ps
module test_auto_fan_speed_control;
  logic       MCLK = 0, RESET = 1, REG_WR = 0, int_seen = 0;
  logic [7:0] REG_ADDR = 0, REG_WDATA = 0, tl = 0, t1 = 0, t2 = 0;
  wire  [7:0] REG_RDATA, DAC_CODE;
  wire        PWM_O, PWM_OE, PWM_ACTIVE, FAN_RUNNING, FAN_INT, pin;
  int         err_count = 0, checks_done = 0;
  logic [7:0] ad [8] = '{8'h00, 8'h04, 8'h05, 8'h10, 8'h11, 8'h12, 8'h14, 8'h20};
  logic [7:0] rv [8] = '{8'h00, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'h7f, 8'h00, 8'h00};
  logic [7:0] tv [3] = '{8'h05, 8'h0a, 8'h1e};
  always #5 MCLK = ~MCLK;
  afsc_top #(.PWM_STEP_CYCLES(4), .SPINUP_CYCLES(20)) uut (.MCLK(MCLK), .RESET(RESET),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA),
    .TEMP_LOCAL(tl), .TEMP_REMOTE1(t1), .TEMP_REMOTE2(t2), .DAC_CODE(DAC_CODE),
    .PWM_O(PWM_O), .PWM_OE(PWM_OE), .PWM_ACTIVE(PWM_ACTIVE), .FAN_RUNNING(FAN_RUNNING),
    .FAN_INT(FAN_INT));
  afsc_fan_stage fan (.pull_low_oe(PWM_OE), .pin_drive(PWM_O), .pin_level(pin));
  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  task automatic give_verdict;
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge MCLK);
      #1;
      int_seen |= FAN_INT;
    end
  endtask : tk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1;
    tk(1);
    REG_WR = 0;
    tk(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    REG_ADDR = a;
    tk(2);
    chk("read data", REG_RDATA, e);
  endtask : rd
  task automatic duty_cnt(output int hi);
    tk(1100);
    hi = 0;
    repeat (1020) begin
      tk(1);
      hi += int'(pin);
    end
  endtask : duty_cnt
  task automatic wfi(input logic run);
    int_seen = 0;
    for (int k = 0; k < 40 && !int_seen; k++) tk(1);
    chk("fan interrupt", int_seen, 1);
    chk("fan running", FAN_RUNNING, run);
    tk(1);
    chk("interrupt length", FAN_INT, 0);
  endtask : wfi
  function automatic int act(input int d);
    return d == 255 ? 1020 : d * 4;
  endfunction : act
  function automatic int ramp(input int mn, input int top, input int diff);
    if (diff <= 0) return mn;
    if (diff > 20) return 255;
    return mn + (top - mn) * diff / 20;
  endfunction : ramp
  //----------------------------------------------------------------------------
  // tests
  //----------------------------------------------------------------------------
  initial begin
    int h, df;
    logic [7:0] v;
    void'($urandom(32'h83b049e4));
    tk(2);
    RESET = 0;
    tk(1);
    for (int i = 0; i < 8; i++) rd(ad[i], rv[i]);
    chk("drive code", DAC_CODE, 8'hff);
    for (int i = 1; i < 8; i++) begin
      v = 8'($urandom);
      wr(ad[i], v);
      rd(ad[i], i == 7 ? 8'h00 : v);
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(8'h04, v);
      chk("drive code", DAC_CODE, v);
    end
    for (int i = 0; i < 8; i++) begin
      v = (i % 4 == 0) ? 8'h00 : (i % 4 == 1) ? 8'h80 : (i % 4 == 2) ? 8'hff : 8'($urandom);
      wr(8'h14, {6'h00, i > 3, 1'b0});
      wr(8'h05, v);
      duty_cnt(h);
      chk("pin high time", h, i < 4 ? act(v) : 1020 - act(v));
    end
    wr(8'h14, 8'h00);
    wr(8'h10, 8'h28);
    wr(8'h11, 8'h7f);
    wr(8'h12, 8'h7f);
    wr(8'h04, 8'h50);
    wr(8'h05, 8'h30);
    wr(8'h00, 8'h60);
    tl = 8'h3c;
    tk(10);
    chk("fan running", FAN_RUNNING, 0);
    tl = 8'h1e;
    t1 = 8'hec;
    tk(2);
    wr(8'h00, 8'h61);
    tl = 8'h29;
    wfi(1);
    chk("spin-up drive", DAC_CODE, 8'hff);
    tk(30);
    chk("drive code", DAC_CODE, ramp(80, 240, 1));
    duty_cnt(h);
    chk("pin high time", h, act(ramp(85, 255, 1)));
    tl = 8'h28;
    tk(4);
    chk("drive code", DAC_CODE, 8'h50);
    wr(8'h11, 8'hf6);
    for (int i = 0; i < 3; i++) begin
      t1 = tv[i];
      tk(4);
      chk("drive code", DAC_CODE, ramp(80, 240, 10 + tv[i]));
    end
    t1 = 8'hec;
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      df = 1 + $urandom % 20;
      wr(8'h04, v);
      tl = 8'(40 + df);
      tk(4);
      chk("drive code", DAC_CODE, ramp(16 * v[7:4], 240, df));
    end
    wr(8'h04, 8'h50);
    tl = 8'h25;
    t1 = 8'hf2;
    tk(6);
    chk("fan running", FAN_RUNNING, 1);
    tl = 8'h24;
    wfi(0);
    chk("drive code", DAC_CODE, 8'h00);
    wr(8'h05, 8'ha0);
    wr(8'h04, 8'h33);
    wr(8'h00, 8'h41);
    tl = 8'h32;
    wfi(1);
    tk(30);
    chk("drive code", DAC_CODE, 8'h33);
    duty_cnt(h);
    chk("pin high time", h, act(ramp(170, 255, 10)));
    // analog output automated alone, pulse back on its register
    wr(8'h00, 8'h21);
    tk(4);
    chk("drive code", DAC_CODE, ramp(48, 240, 10));
    duty_cnt(h);
    chk("pin high time", h, act(8'ha0));
    int_seen = 0;
    wr(8'h00, 8'h00);
    tk(5);
    chk("fan running", FAN_RUNNING, 0);
    chk("fan interrupt", int_seen, 0);
    give_verdict;
  end
  initial begin
    repeat (80000) @(posedge MCLK);
    err_count++;
    give_verdict;
  end
endmodule : test_auto_fan_speed_control
